// >>> core/rtu_check_pkg.sv
// Constants and types for the RTU error checking and exception block
package rtu_check_pkg;

    // CRC
    localparam logic [15:0] CRC_INIT     = 16'hffff;
    localparam logic [15:0] CRC_POLY     = 16'ha001;
    localparam int          CRC_STEPS    = 8;

    // Function field
    localparam logic [7:0]  FUNC_EXC_BIT = 8'h80;

    // Exception codes
    localparam logic [7:0]  EXC_ILLEGAL_FUNCTION = 8'h01;
    localparam logic [7:0]  EXC_ILLEGAL_ADDRESS  = 8'h02;
    localparam logic [7:0]  EXC_ILLEGAL_VALUE    = 8'h03;
    localparam logic [7:0]  EXC_DEVICE_FAILURE   = 8'h04;
    localparam logic [7:0]  EXC_ACKNOWLEDGE      = 8'h05;
    localparam logic [7:0]  EXC_DEVICE_BUSY      = 8'h06;
    localparam logic [7:0]  EXC_NEG_ACKNOWLEDGE  = 8'h07;
    localparam logic [7:0]  EXC_MEMORY_PARITY    = 8'h08;

    // Data encodings
    localparam logic signed [15:0] PCT_FULL_SCALE = 16'sd20000;
    localparam int                 PCT_MILLI_PER_LSB = 5;
    localparam int                 TEMP_DECI_C_PER_LSB = 1;

    // Broadcast address
    localparam logic [7:0]  BCAST_ADDR = 8'h00;

    // Parity modes
    typedef enum logic [1:0] {
        PAR_NONE,
        PAR_EVEN,
        PAR_ODD
    } parity_mode_t;

    // Exception request from command handlers
    typedef enum logic [3:0] {
        FAULT_NONE,
        FAULT_FUNCTION,
        FAULT_ADDRESS,
        FAULT_VALUE,
        FAULT_FAILURE,
        FAULT_ACK,
        FAULT_BUSY,
        FAULT_NAK,
        FAULT_MEMORY
    } fault_t;

    // Transmit phases
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_BODY,
        TX_CRC_LO,
        TX_CRC_HI
    } tx_state_t;

endpackage : rtu_check_pkg

// >>> core/crc16_step.sv
// One-byte CRC-16 update, reflected form
`timescale 1ns/100ps
`default_nettype none

module crc16_step
    import rtu_check_pkg::*;
(
    // Current register and byte in
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data_in,
    // Updated register
    output logic      [15:0] crc_out
);

    always_comb begin
        logic [15:0] r;
        r = crc_in ^ {8'h00, data_in};                          // R13
        for (int i = 0; i < CRC_STEPS; i++) begin
            if (r[0]) begin
                r = {1'b0, r[15:1]} ^ CRC_POLY;                 // R14 R16
            end else begin
                r = {1'b0, r[15:1]};                            // R14
            end
        end
        crc_out = r;
    end

endmodule : crc16_step

`default_nettype wire

// >>> core/rtu_check.sv
// Parity, frame CRC and exception response logic for an RTU slave
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// R01 - All values travel as 16-bit registers
// R02 - Counts are signed 16-bit two's complement
// R03 - Percent: 0.005 per lsb, 20000 full
// R04 - Temperature: tenth degree per lsb, signed
// R05 - Discretes: one bit per channel, one=on/high
// R06 - Append even or odd parity bit
// R07 - Flag received parity mismatch per character
// R08 - No parity: no check, extra stop bit
// R09 - Master uses same parity as slaves
// R10 - CRC last, low byte then high byte
// R11 - Receiver compares computed and received CRC
// R12 - CRC register starts at all ones
// R13 - Only data bits enter the CRC
// R14 - Eight shift-and-conditional-xor steps per byte
// R15 - Final register contents are the CRC
// R16 - Shift constant is A001 hex
// R17 - Unsupported function returns exception 01
// R18 - Invalid holding value returns exception 03
// R19 - Unsupported address returns exception 02
// R20 - Codes 04 through 08 as tabled
// R21 - Normal response echoes function code below 80H
// R22 - Exception sets function msb, carries code
// R23 - Master detects exception by function msb
// R24 - No response to broadcast queries
// R25 - Frames with parity/CRC error get no reply
module rtu_check
    import rtu_check_pkg::*;
#(
    parameter int DATA_W = 16
)
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // Configuration
    input  wire logic [1:0]        parity_sel,
    output logic                   two_stop_bits,
    // Received characters
    input  wire logic              rx_char_valid,
    input  wire logic [7:0]        rx_char_data,
    input  wire logic              rx_char_parity,
    input  wire logic              rx_frame_start,
    input  wire logic              rx_frame_end,
    // Receive status
    output logic                   rx_parity_err,
    output logic                   rx_frame_done,
    output logic                   rx_frame_good,
    output logic                   rx_crc_err,
    output logic [7:0]             rx_addr,
    output logic [7:0]             rx_func,
    output logic [15:0]            rx_crc_calc,
    // Response request from command handlers
    input  wire logic              resp_start,
    input  wire logic [3:0]        resp_fault,
    // Exception encoding
    output logic [7:0]             resp_func,
    output logic [7:0]             resp_exc_code,
    output logic                   resp_is_exc,
    output logic                   resp_allowed,
    // Transmit byte stream
    input  wire logic              tx_body_valid,
    input  wire logic [7:0]        tx_body_data,
    input  wire logic              tx_body_last,
    output logic                   tx_body_ready,
    output logic                   tx_char_valid,
    output logic [7:0]             tx_char_data,
    output logic                   tx_char_parity,
    input  wire logic              tx_char_ready,
    output logic                   tx_busy,
    // Data encodings
    input  wire logic signed [DATA_W-1:0] pct_in,               // R02 R03
    output logic                   pct_over_range,
    input  wire logic [DATA_W-1:0] discrete_in,
    output logic [DATA_W-1:0]      discrete_reg_q
);

    ////////////////////////////////////////////////////////////////////////
    // Parity configuration

    parity_mode_t par_mode;

    always_comb begin
        case (parity_sel)
            2'h1:    par_mode = PAR_EVEN;
            2'h2:    par_mode = PAR_ODD;
            default: par_mode = PAR_NONE;
        endcase
    end

    assign two_stop_bits = (par_mode == PAR_NONE);                      // R08

    function automatic logic parity_of(input logic [7:0] d, input parity_mode_t m);
        parity_of = (m == PAR_ODD) ? ~(^d) : (^d);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Receive CRC and parity

    logic [15:0] rx_crc_q;
    logic [15:0] rx_crc_d;
    logic [7:0]  rx_last_q;
    logic [7:0]  rx_prev_q;
    logic [15:0] rx_crc_lag1_q;
    logic [15:0] rx_crc_lag2_q;
    logic [7:0]  rx_count_q;
    logic        rx_perr_frame_q;
    logic        char_perr;

    crc16_step u_rx_crc (
        .crc_in  (rx_crc_q),
        .data_in (rx_char_data),
        .crc_out (rx_crc_d)
    );

    assign char_perr = (par_mode != PAR_NONE) &&
                       (parity_of(rx_char_data, par_mode) != rx_char_parity);   // R07 R08

    always_ff @(posedge clk) begin
        if (srst || rx_frame_start) begin
            rx_crc_q      <= CRC_INIT;                                  // R12
            rx_crc_lag1_q <= CRC_INIT;
            rx_crc_lag2_q <= CRC_INIT;
            rx_count_q    <= 8'h00;
            rx_last_q     <= 8'h00;
            rx_prev_q     <= 8'h00;
        end else if (rx_char_valid) begin
            rx_crc_q      <= rx_crc_d;                                  // R11
            rx_crc_lag1_q <= rx_crc_q;
            rx_crc_lag2_q <= rx_crc_lag1_q;
            rx_prev_q     <= rx_last_q;
            rx_last_q     <= rx_char_data;
            if (rx_count_q != 8'hff) begin
                rx_count_q <= rx_count_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_addr <= 8'h00;
            rx_func <= 8'h00;
        end else if (rx_char_valid && rx_count_q == 8'h00) begin
            rx_addr <= rx_char_data;
        end else if (rx_char_valid && rx_count_q == 8'h01) begin
            rx_func <= rx_char_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_parity_err   <= 1'b0;
            rx_perr_frame_q <= 1'b0;
        end else begin
            rx_parity_err <= rx_char_valid && char_perr;                // R07
            if (rx_frame_start) begin
                rx_perr_frame_q <= 1'b0;
            end else if (rx_char_valid && char_perr) begin
                rx_perr_frame_q <= 1'b1;
            end
        end
    end

    // Frame verdict: CRC over body compared with trailing two bytes
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_frame_done <= 1'b0;
            rx_frame_good <= 1'b0;
            rx_crc_err    <= 1'b0;
            rx_crc_calc   <= 16'h0000;
        end else begin
            rx_frame_done <= rx_frame_end;
            if (rx_frame_end) begin
                rx_crc_calc   <= rx_crc_lag2_q;                         // R15
                rx_crc_err    <= (rx_count_q < 8'h04) ||
                                 (rx_crc_lag2_q != {rx_last_q, rx_prev_q});  // R10 R11
                rx_frame_good <= (rx_count_q >= 8'h04) && !rx_perr_frame_q &&
                                 (rx_crc_lag2_q == {rx_last_q, rx_prev_q});   // R25
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Exception encoding

    always_ff @(posedge clk) begin
        if (srst) begin
            resp_exc_code <= 8'h00;
            resp_is_exc   <= 1'b0;
            resp_func     <= 8'h00;
        end else if (resp_start) begin
            resp_is_exc <= (resp_fault != FAULT_NONE);
            case (resp_fault)
                FAULT_FUNCTION: resp_exc_code <= EXC_ILLEGAL_FUNCTION;  // R17
                FAULT_ADDRESS:  resp_exc_code <= EXC_ILLEGAL_ADDRESS;   // R19
                FAULT_VALUE:    resp_exc_code <= EXC_ILLEGAL_VALUE;     // R18
                FAULT_FAILURE:  resp_exc_code <= EXC_DEVICE_FAILURE;    // R20
                FAULT_ACK:      resp_exc_code <= EXC_ACKNOWLEDGE;       // R20
                FAULT_BUSY:     resp_exc_code <= EXC_DEVICE_BUSY;       // R20
                FAULT_NAK:      resp_exc_code <= EXC_NEG_ACKNOWLEDGE;   // R20
                FAULT_MEMORY:   resp_exc_code <= EXC_MEMORY_PARITY;     // R20
                default:        resp_exc_code <= 8'h00;
            endcase
            if (resp_fault != FAULT_NONE) begin
                resp_func <= rx_func | FUNC_EXC_BIT;                    // R22
            end else begin
                resp_func <= rx_func & ~FUNC_EXC_BIT;                   // R21
            end
        end
    end

    assign resp_allowed = rx_frame_good && (rx_addr != BCAST_ADDR);    // R24 R25

    ////////////////////////////////////////////////////////////////////////
    // Transmit CRC append

    tx_state_t   tx_state_q;
    logic [15:0] tx_crc_q;
    logic [15:0] tx_crc_d;
    logic [7:0]  tx_byte;
    logic        tx_take;
    logic [15:0] u_tx_first;

    // CRC of first byte computed from the preset value
    crc16_step u_tx_first_crc (
        .crc_in  (CRC_INIT),
        .data_in (tx_body_data),
        .crc_out (u_tx_first)
    );

    crc16_step u_tx_crc (
        .crc_in  (tx_crc_q),
        .data_in (tx_body_data),
        .crc_out (tx_crc_d)
    );

    assign tx_body_ready = tx_char_ready &&
                           (tx_state_q == TX_IDLE || tx_state_q == TX_BODY);
    assign tx_take       = tx_body_valid && tx_body_ready;
    assign tx_busy       = (tx_state_q != TX_IDLE);

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_state_q <= TX_IDLE;
            tx_crc_q   <= CRC_INIT;
        end else begin
            case (tx_state_q)
                TX_IDLE, TX_BODY: begin
                    if (tx_take) begin
                        tx_crc_q   <= (tx_state_q == TX_IDLE)
                                      ? u_tx_first : tx_crc_d;           // R12
                        tx_state_q <= tx_body_last ? TX_CRC_LO : TX_BODY;
                    end
                end
                TX_CRC_LO: begin
                    if (tx_char_ready) begin
                        tx_state_q <= TX_CRC_HI;                        // R10
                    end
                end
                default: begin
                    if (tx_char_ready) begin
                        tx_state_q <= TX_IDLE;
                        tx_crc_q   <= CRC_INIT;                         // R12
                    end
                end
            endcase
        end
    end

    always_comb begin
        case (tx_state_q)
            TX_CRC_LO: tx_byte = tx_crc_q[7:0];                         // R10 R15
            TX_CRC_HI: tx_byte = tx_crc_q[15:8];                        // R10
            default:   tx_byte = tx_body_data;
        endcase
    end

    assign tx_char_valid = (tx_state_q == TX_CRC_LO) || (tx_state_q == TX_CRC_HI) ||
                           tx_body_valid;
    assign tx_char_data  = tx_byte;
    assign tx_char_parity = (par_mode == PAR_NONE) ? 1'b1
                                                   : parity_of(tx_byte, par_mode); // R06

    ////////////////////////////////////////////////////////////////////////
    // Data encodings

    assign pct_over_range = (pct_in > PCT_FULL_SCALE) || (pct_in < -PCT_FULL_SCALE); // R03

    always_ff @(posedge clk) begin
        if (srst) begin
            discrete_reg_q <= '0;
        end else begin
            discrete_reg_q <= discrete_in;                              // R05 R01
        end
    end

endmodule : rtu_check

`default_nettype wire

// >>> dv/rtu_check_props.sv
// Port-level checks for the RTU check block
`timescale 1ns/100ps
`default_nettype none
module rtu_check_props
    import rtu_check_pkg::*;
#(
    parameter int DATA_W = 16
)
(
    // Clock, reset, mode
    input wire logic       clk,
    input wire logic       srst,
    input wire logic [1:0] parity_sel,
    input wire logic       two_stop_bits,
    // Receive
    input wire logic       rx_char_valid,
    input wire logic [7:0] rx_char_data,
    input wire logic       rx_char_parity,
    input wire logic       rx_frame_end,
    input wire logic       rx_parity_err,
    input wire logic       rx_frame_done,
    input wire logic       rx_frame_good,
    input wire logic [7:0] rx_addr,
    input wire logic [7:0] rx_func,
    // Response
    input wire logic       resp_start,
    input wire logic [3:0] resp_fault,
    input wire logic [7:0] resp_func,
    input wire logic [7:0] resp_exc_code,
    input wire logic       resp_is_exc,
    input wire logic       resp_allowed,
    // Transmit
    input wire logic       tx_body_valid,
    input wire logic       tx_body_last,
    input wire logic       tx_body_ready,
    input wire logic       tx_char_valid,
    input wire logic [7:0] tx_char_data,
    input wire logic       tx_char_parity,
    // Percent
    input wire logic signed [DATA_W-1:0] pct_in,
    input wire logic       pct_over_range
);
    logic par_on, bad_par, exp_par;
    assign par_on  = parity_sel == 2'h1 || parity_sel == 2'h2;
    assign bad_par = rx_char_valid && par_on && ((^rx_char_data ^ rx_char_parity) != (parity_sel == 2'h2));
    assign exp_par = !par_on || ((^tx_char_data) ^ (parity_sel == 2'h2));
    default clocking dc @(posedge clk); endclocking
    default disable iff (srst);
    sequence last_acc; tx_body_valid && tx_body_ready && tx_body_last; endsequence
    sequence crc_phase; tx_char_valid && !tx_body_ready; endsequence
    par_flag_a: assert property (1'b1 |=> rx_parity_err == $past(bad_par)) else $error("parity flag wrong");
    stop_bits_a: assert property (two_stop_bits == !par_on) else $error("stop bit mode wrong");
    tx_parity_a: assert property (tx_char_valid |-> tx_char_parity == exp_par) else $error("tx parity wrong");
    frame_done_a: assert property (1'b1 |=> rx_frame_done == $past(rx_frame_end)) else $error("done late");
    exc_resp_a: assert property (resp_start && resp_fault != 4'h0 |=> resp_is_exc
        && resp_func == ($past(rx_func) | FUNC_EXC_BIT) && resp_exc_code == {4'h0, $past(resp_fault)})
        else $error("exception response wrong");
    norm_resp_a: assert property (resp_start && resp_fault == 4'h0 |=> !resp_is_exc
        && resp_func == $past(rx_func)) else $error("normal response wrong");
    no_bcast_a: assert property (resp_allowed == (rx_frame_good && rx_addr != BCAST_ADDR))
        else $error("reply permission wrong");
    crc_tail_a: assert property (last_acc |=> crc_phase) else $error("crc bytes not next");
    pct_range_a: assert property (pct_over_range == (pct_in > PCT_FULL_SCALE || pct_in < -PCT_FULL_SCALE))
        else $error("percent range wrong");
endmodule // rtu_check_props
bind rtu_check rtu_check_props #(.DATA_W(DATA_W)) props (.*);
`default_nettype wire

// >>> dv/rtu_master_model.sv
// Network master stand-in: sends queries, takes replies
`timescale 1ns/100ps
`default_nettype none
module rtu_master_model
(
    // Clock and mode
    input wire logic       clk,
    input wire logic [1:0] parity_sel,
    input wire logic       slow,
    // Query characters
    output logic           rx_char_valid,
    output logic [7:0]     rx_char_data,
    output logic           rx_char_parity,
    output logic           rx_frame_start,
    output logic           rx_frame_end,
    // Reply characters
    input wire logic       tx_char_valid,
    input wire logic [7:0] tx_char_data,
    input wire logic       tx_char_parity,
    output logic           tx_char_ready
);
    logic [8:0] got[$];
    initial {rx_char_valid, rx_char_data, rx_char_parity, rx_frame_start, rx_frame_end, tx_char_ready} = '0;
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    function automatic logic par(input logic [7:0] d);
        return (parity_sel == 2'h1 || parity_sel == 2'h2) ? ^d ^ (parity_sel == 2'h2) : 1'b1;
    endfunction
    task automatic send(input logic [7:0] b[$], input int flip, input logic [15:0] cx);
        logic [15:0] c;
        c = crc16(b) ^ cx;
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        rx_frame_start <= 1'b1;
        @(posedge clk);
        rx_frame_start <= 1'b0;
        foreach (b[i]) begin
            rx_char_valid <= 1'b1;
            rx_char_data <= b[i];
            rx_char_parity <= par(b[i]) ^ (i == flip);
            @(posedge clk);
        end
        rx_char_valid <= 1'b0;
        rx_char_data <= ~rx_char_data;
        rx_frame_end <= 1'b1;
        @(posedge clk);
        rx_frame_end <= 1'b0;
    endtask
    // Stalls every other cycle when slow
    always @(posedge clk) begin
        tx_char_ready <= slow ? ~tx_char_ready : 1'b1;
        if (tx_char_valid && tx_char_ready)
            got.push_back({tx_char_parity, tx_char_data});
    end
endmodule // rtu_master_model
`default_nettype wire

// >>> dv/rtu_check_bench.sv
// Self-checking bench for the RTU check block
`timescale 1ns/100ps
`default_nettype none
module rtu_check_bench
    import rtu_check_pkg::*;
;
    logic clk, srst, slow, two_stop_bits, rx_char_valid, rx_char_parity, rx_frame_start, rx_frame_end;
    logic rx_parity_err, rx_frame_done, rx_frame_good, rx_crc_err, resp_start, resp_is_exc, resp_allowed;
    logic tx_body_valid, tx_body_last, tx_body_ready, tx_char_valid, tx_char_parity, tx_char_ready;
    logic tx_busy, pct_over_range;
    logic [1:0] parity_sel;
    logic [3:0] resp_fault;
    logic [7:0] rx_char_data, rx_addr, rx_func, resp_func, resp_exc_code, tx_body_data, tx_char_data;
    logic [15:0] rx_crc_calc, discrete_in, discrete_reg_q;
    logic signed [15:0] pct_in;
    int bad_count, checks, perr;
    rtu_check #(.DATA_W(16)) dut (.*);
    rtu_master_model m (.*);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) if (rx_parity_err === 1'b1) perr++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic frame(input logic [7:0] b[$], input int flip, input logic [15:0] cx);
        perr = 0;
        m.send(b, flip, cx);
        @(posedge clk);
        chk(rx_frame_done, 1'b1);
    endtask
    task automatic t_rx;
        logic [7:0] q[$];
        q = '{8'hf7, 8'h03, 8'h00, 8'h6b, 8'h00, 8'h03};
        for (int k = 0; k < 3; k++) begin
            parity_sel <= 2'(k);
            @(posedge clk);
            frame(q, -1, 16'h0000);
            chk(rx_frame_good, 1'b1);
            chk({rx_addr, rx_func}, 16'hf703);
            chk(rx_crc_calc, m.crc16(q));
            chk(resp_allowed, 1'b1);
            chk(perr, 0);
            frame(q, 3, 16'h0000);
            chk(perr, k != 0);
            chk(resp_allowed, k == 0);
            frame(q, -1, 16'h0100);
            chk(rx_crc_err, 1'b1);
            chk(resp_allowed, 1'b0);
        end
        q[0] = BCAST_ADDR;
        frame(q, -1, 16'h0000);
        chk(rx_frame_good, 1'b1);
        chk(resp_allowed, 1'b0);
        $display("t_rx finished");
    endtask
    task automatic t_resp;
        for (int f = 0; f < 9; f++) begin
            resp_fault <= 4'(f);
            resp_start <= 1'b1;
            @(posedge clk);
            resp_start <= 1'b0;
            @(posedge clk);
            chk(resp_is_exc, f != 0);
            chk(resp_func[7], f != 0);
            chk(resp_func, f != 0 ? 8'h83 : 8'h03);
            if (f != 0) chk(resp_exc_code, 8'(f));
        end
        $display("t_resp finished");
    endtask
    task automatic t_tx;
        logic [7:0] q[$], e[$];
        logic [15:0] c;
        int n;
        q = '{8'hf7, 8'h11, 8'h5a};
        c = m.crc16(q);
        e = {q, c[7:0], c[15:8]};
        for (int k = 0; k < 4; k++) begin
            parity_sel <= 2'(k);
            slow <= k % 2 == 1;
            m.got.delete();
            @(posedge clk);
            chk(tx_busy, 1'b0);
            foreach (q[i]) begin
                tx_body_valid <= 1'b1;
                tx_body_data <= q[i];
                tx_body_last <= i == 2;
                n = 0;
                do begin @(posedge clk); n++; end while (tx_body_ready !== 1'b1 && n < 50);
            end
            tx_body_valid <= 1'b0;
            tx_body_last <= 1'b0;
            chk(tx_busy, 1'b1);
            n = 0;
            while (m.got.size() < 5 && n < 50) begin @(posedge clk); n++; end
            chk(two_stop_bits, k % 3 == 0);
            chk(m.got.size(), 5);
            foreach (e[i]) chk(m.got[i], {m.par(e[i]), e[i]});
        end
        $display("t_tx finished");
    endtask
    task automatic t_enc;
        logic signed [15:0] v[5];
        v = '{16'sd20000, 16'sd20001, -16'sd20000, -16'sd20001, 16'sd0};
        foreach (v[i]) begin
            pct_in <= v[i];
            discrete_in <= v[i];
            repeat (2) @(posedge clk);
            chk(pct_over_range, i % 2);
            chk(discrete_reg_q, $unsigned(v[i]));
        end
        $display("t_enc finished");
    endtask
    initial begin
        srst = 1'b1;
        {slow, parity_sel, resp_start, resp_fault, tx_body_valid, tx_body_data, tx_body_last} = '0;
        {pct_in, discrete_in} = '0;
        {bad_count, checks, perr} = '0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_rx;
        t_resp;
        t_tx;
        t_enc;
        final_report;
    end
    // Watchdog
    initial begin
        #100000;
        bad_count++;
        final_report;
    end
endmodule // rtu_check_bench
`default_nettype wire
